// *** rtl/ccpu_cfg.svh ***
/*
 * Constants of the capture/compare/PWM unit: register offsets, field
 * positions, reset values and prescaler masks.
 * Assumes it is included by bare name by every module of the unit.
 */
// Notes on behaviour
// - mode 0000 disables, resets; 0001/0011 do nothing
// - mode 0010 toggles pin, sets flag on match
// - capture: fall, rise, 4th rise, 16th rise
// - mode 1000: start low, match forces high
// - mode 1001: start high, match forces low
// - mode 1010: flag only, pin left to port
// - mode 1011: flag, timer reset, second starts conversion
// - first instance never requests a conversion
// - PWM duty is data low byte plus two bits
// - control and both data bytes are read/write
// - capture/compare use 16-bit timers, PWM period timer
// - external select picks timer per instance
// - both PWMs share the period timer event
// - open-drain select per instance for output modes
// - route bit moves second pin, default primary
// - capture copies selected timer into data
// - capture sets flag; only software clears it
// - new capture overwrites unread data
// - capture still sees pin while driven
// - capture mode change may raise spurious flag
// - prescaler cleared when off or not capturing
// - switching prescalers keeps counter, may fire early
// - compare data against selected timer for match
`ifndef CCPU_CFG_SVH
`define CCPU_CFG_SVH

`define CCPU_TW          16
`define CCPU_SUB_CTRL    4'h0
`define CCPU_SUB_DLOW    4'h4
`define CCPU_SUB_DHIGH   4'h8
`define CCPU_OFS_FLAGS   8'h20
`define CCPU_OFS_STATUS  8'h24
`define CCPU_CTRL_MASK   8'h3F
`define CCPU_CTRL_RST    8'h00
`define CCPU_DUTY_HI     5
`define CCPU_DUTY_LO     4
`define CCPU_MODE_HI     3
`define CCPU_GRP_CAP     2'h1
`define CCPU_GRP_CMP     2'h2
`define CCPU_GRP_PWM     2'h3
`define CCPU_TSEL_BOTHB  1
`define CCPU_TSEL_SPLIT  0
`define CCPU_PS4_MASK    4'h3
`define CCPU_PS16_MASK   4'hF
`define CCPU_PS_CLR      4'h0

`endif

// *** rtl/ccpu_pkg.sv ***
/*
 * Types of the capture/compare/PWM unit: mode encoding and the state
 * records of each module.
 * Assumes ccpu_cfg.svh is on the include path.
 */
`include "ccpu_cfg.svh"
package ccpu_pkg;
	typedef enum logic [3:0] {
		CCPU_M_OFF      = 4'h0,
		CCPU_M_RSV1     = 4'h1,
		CCPU_M_TOGGLE   = 4'h2,
		CCPU_M_RSV3     = 4'h3,
		CCPU_M_CAP_FALL = 4'h4,
		CCPU_M_CAP_RISE = 4'h5,
		CCPU_M_CAP_4    = 4'h6,
		CCPU_M_CAP_16   = 4'h7,
		CCPU_M_SET_HI   = 4'h8,
		CCPU_M_SET_LO   = 4'h9,
		CCPU_M_SOFT     = 4'hA,
		CCPU_M_SPECIAL  = 4'hB,
		CCPU_M_PWM_0    = 4'hC,
		CCPU_M_PWM_1    = 4'hD,
		CCPU_M_PWM_2    = 4'hE,
		CCPU_M_PWM_3    = 4'hF
	} ccpu_mode_e;

	typedef struct packed {
		logic [2:0] stage;
		logic       level;
		logic       rise;
		logic       fall;
	} ccpu_sync_s;

	typedef struct packed {
		logic [3:0] count;
	} ccpu_pre_s;

	typedef struct packed {
		logic [1:0][7:0]           ctrl;
		logic [1:0][`CCPU_TW-1:0]  data;
		logic [1:0][9:0]           duty;
		logic [1:0]                latch;
		logic [1:0]                matchPrev;
		logic [1:0]                flag;
		logic                      timerARst;
		logic                      timerBRst;
		logic                      adcStart;
		logic                      pinAOut;
		logic                      pinAOe;
		logic                      primOut;
		logic                      primOe;
		logic                      altOut;
		logic                      altOe;
		logic [31:0]               prdata;
		logic                      pready;
		logic                      pslverr;
	} ccpu_top_s;
endpackage

// *** rtl/ccpu_pin_sync.sv ***
/*
 * Three-stage synchroniser for a capture pin with edge pulses.
 * Assumes the pin is asynchronous to ref_clk.
 */
`timescale 1ns/1ps
`include "ccpu_cfg.svh"
module ccpu_pin_sync (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic clkEn,
	// pin and edges
	input  wire logic pinIn,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	ccpu_pkg::ccpu_sync_s s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.stage = {s_q.stage[1:0], pinIn};
		s_d.rise = 1'b0;
		s_d.fall = 1'b0;
		if ((s_q.stage[1] == s_q.stage[2]) && (s_q.stage[2] != s_q.level)) begin
			s_d.level = s_q.stage[2];
			s_d.rise = s_q.stage[2];
			s_d.fall = !s_q.stage[2];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	assign level = s_q.level;
	assign rise  = s_q.rise;
	assign fall  = s_q.fall;

	a_sync_agree: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clkEn && s_q.stage[1] != s_q.stage[2]) |=> $stable(s_q.level))
		else $error("pin level moved without agreeing samples");
endmodule

// *** rtl/ccpu_prescaler.sv ***
/*
 * Capture event selection and prescaler counter for one instance.
 * Assumes rise/fall are one-cycle pulses from the pin synchroniser.
 */
`timescale 1ns/1ps
`include "ccpu_cfg.svh"
module ccpu_prescaler (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       clkEn,
	// mode and edges
	input  wire logic [3:0] mode,
	input  wire logic       rise,
	input  wire logic       fall,
	// event
	output logic            capture
);
	ccpu_pkg::ccpu_pre_s s_q, s_d;
	logic [3:0]          mask;

	always_comb begin
		s_d = s_q;
		capture = 1'b0;
		mask = `CCPU_PS16_MASK;
		case (ccpu_pkg::ccpu_mode_e'(mode))
			ccpu_pkg::CCPU_M_CAP_FALL: capture = fall;
			ccpu_pkg::CCPU_M_CAP_RISE: capture = rise;
			ccpu_pkg::CCPU_M_CAP_4, ccpu_pkg::CCPU_M_CAP_16: begin
				if (mode == ccpu_pkg::CCPU_M_CAP_4) begin
					mask = `CCPU_PS4_MASK;
				end
				if (rise) begin
					capture = ((s_q.count & mask) == mask);
					s_d.count = s_q.count + 4'h1;
				end
			end
			default: s_d.count = `CCPU_PS_CLR;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	a_prescale_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clkEn && mode[3:2] != `CCPU_GRP_CAP) |=> (s_q.count == `CCPU_PS_CLR))
		else $error("prescaler not cleared outside capture");
endmodule

// *** rtl/ccpu_top.sv ***
/*
 * Two-instance capture/compare/PWM unit with an APB register slave.
 * Assumes timers, period timer and port latches live outside, on
 * ref_clk; pins are asynchronous and resolved by the testbench.
 */
`timescale 1ns/1ps
`include "ccpu_cfg.svh"
module ccpu_top (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              clkEn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// timer bases
	input  wire logic [`CCPU_TW-1:0] timerACount,
	input  wire logic [`CCPU_TW-1:0] timerBCount,
	input  wire logic [1:0]        timerSelect,
	input  wire logic [7:0]        periodTimer,
	input  wire logic              periodEvent,
	// pin configuration
	input  wire logic [1:0]        openDrainSel,
	input  wire logic              secondPinRouteCfg,
	// first instance pin
	input  wire logic              pinAIn,
	output logic                   pinAOut,
	output logic                   pinAOe,
	// second instance pins
	input  wire logic              primaryPortPinIn,
	output logic                   primaryPortPinOut,
	output logic                   primaryPortPinOe,
	input  wire logic              alternatePortPinIn,
	output logic                   alternatePortPinOut,
	output logic                   alternatePortPinOe,
	// side effects
	output logic [1:0]             unitIrqFlag,
	output logic                   timerAReset,
	output logic                   timerBReset,
	output logic                   adcStart
);

	////////////////////////////////////////////////////////////////////

	ccpu_pkg::ccpu_top_s        s_q, s_d;
	logic [1:0][`CCPU_TW-1:0]   timerVal;
	logic [1:0][3:0]            mode;
	logic [1:0]                 useB;
	logic [1:0]                 capMode;
	logic [1:0]                 cmpMode;
	logic [1:0]                 pwmMode;
	logic [1:0]                 match;
	logic [1:0]                 matchEv;
	logic [1:0]                 pinIn;
	logic [1:0]                 pinLevel;
	logic [1:0]                 rise;
	logic [1:0]                 fall;
	logic [1:0]                 capEv;
	logic                       ch;
	logic                       inChan;
	logic                       wrEn;
	logic [31:0]                rdVal;
	logic                       rdErr;

	function automatic logic drivesPin(input logic [3:0] m);
		drivesPin = (m[3:2] == `CCPU_GRP_PWM) || (m == ccpu_pkg::CCPU_M_TOGGLE) ||
			((m[3:2] == `CCPU_GRP_CMP) && (m != ccpu_pkg::CCPU_M_SOFT));
	endfunction

	////////////////////////////////////////////////////////////////////

	assign pinIn[0] = pinAIn;
	assign pinIn[1] = secondPinRouteCfg ? primaryPortPinIn : alternatePortPinIn;

	genvar g;
	for (g = 0; g < 2; g++) begin : gCh
		assign useB[g] = timerSelect[`CCPU_TSEL_BOTHB] |
			(timerSelect[`CCPU_TSEL_SPLIT] & (g == 1));
		assign timerVal[g] = useB[g] ? timerBCount : timerACount;
		assign mode[g]     = s_q.ctrl[g][`CCPU_MODE_HI:0];
		assign capMode[g]  = (mode[g][3:2] == `CCPU_GRP_CAP);
		assign cmpMode[g]  = (mode[g][3:2] == `CCPU_GRP_CMP) ||
			(mode[g] == ccpu_pkg::CCPU_M_TOGGLE);
		assign pwmMode[g]  = (mode[g][3:2] == `CCPU_GRP_PWM);
		assign match[g]    = cmpMode[g] && (s_q.data[g] == timerVal[g]);
		assign matchEv[g]  = match[g] && !s_q.matchPrev[g];

		ccpu_pin_sync uSync (
			.ref_clk (ref_clk),
			.rst_n   (rst_n),
			.clkEn   (clkEn),
			.pinIn   (pinIn[g]),
			.level   (pinLevel[g]),
			.rise    (rise[g]),
			.fall    (fall[g])
		);

		ccpu_prescaler uPre (
			.ref_clk (ref_clk),
			.rst_n   (rst_n),
			.clkEn   (clkEn),
			.mode    (mode[g]),
			.rise    (rise[g]),
			.fall    (fall[g]),
			.capture (capEv[g])
		);
	end

	////////////////////////////////////////////////////////////////////
	// apb decode: one access cycle, read data staged in setup

	assign ch     = paddr[4];
	assign inChan = (paddr < `CCPU_OFS_FLAGS);
	assign wrEn   = psel && penable && s_q.pready && pwrite;

	always_comb begin
		rdVal = 32'h0;
		rdErr = 1'b0;
		if (inChan) begin
			case (paddr[3:0])
				`CCPU_SUB_CTRL:  rdVal[7:0] = s_q.ctrl[ch] & `CCPU_CTRL_MASK;
				`CCPU_SUB_DLOW:  rdVal[7:0] = s_q.data[ch][7:0];
				`CCPU_SUB_DHIGH: rdVal[7:0] = s_q.data[ch][15:8];
				default:         rdErr = 1'b1;
			endcase
		end else if (paddr == `CCPU_OFS_FLAGS) begin
			rdVal[2:0] = {s_q.flag, 1'b0};
		end else if (paddr == `CCPU_OFS_STATUS) begin
			rdVal[3:0] = {pinLevel, s_q.latch};
		end else begin
			rdErr = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////

	always_comb begin
		logic [7:0] newCtrl;
		logic [9:0] newDuty;
		logic [1:0] lvl;
		logic [1:0] oe;
		logic [1:0] out;
		newCtrl = pwdata[7:0] & `CCPU_CTRL_MASK;
		newDuty = 10'h000;
		lvl = 2'h0;
		oe = 2'h0;
		out = 2'h0;
		s_d = s_q;
		s_d.pready = psel && !penable;
		if (psel && !penable) begin
			s_d.prdata = rdVal;
			s_d.pslverr = rdErr;
		end
		s_d.timerARst = 1'b0;
		s_d.timerBRst = 1'b0;
		s_d.adcStart = 1'b0;
		if (wrEn && (paddr == `CCPU_OFS_FLAGS)) begin
			s_d.flag = s_q.flag & ~pwdata[2:1];
		end
		for (int i = 0; i < 2; i++) begin
			// off resets instance
			// applied first, so a write leaving off still sets its entry level
			if (mode[i] == ccpu_pkg::CCPU_M_OFF) begin
				s_d.latch[i] = 1'b0;
				s_d.matchPrev[i] = 1'b0;
				s_d.duty[i] = 10'h000;
			end
			if (wrEn && inChan && (ch == 1'(i))) begin
				case (paddr[3:0])
					`CCPU_SUB_CTRL: begin
						s_d.ctrl[i] = newCtrl;
						if (newCtrl == `CCPU_CTRL_RST) begin
							s_d.latch[i] = 1'b0;
						end
						if (newCtrl[3:0] != mode[i]) begin
							if (newCtrl[3:0] == ccpu_pkg::CCPU_M_SET_HI) begin
								s_d.latch[i] = 1'b0;
							end
							if (newCtrl[3:0] == ccpu_pkg::CCPU_M_SET_LO) begin
								s_d.latch[i] = 1'b1;
							end
						end
					end
					`CCPU_SUB_DLOW:  s_d.data[i][7:0] = pwdata[7:0];
					`CCPU_SUB_DHIGH: s_d.data[i][15:8] = pwdata[7:0];
					default: ;
				endcase
			end
			s_d.matchPrev[i] = match[i];
			if (matchEv[i]) begin
				case (ccpu_pkg::ccpu_mode_e'(mode[i]))
					ccpu_pkg::CCPU_M_TOGGLE: begin
						s_d.latch[i] = !s_q.latch[i];
						s_d.flag[i] = 1'b1;
					end
					ccpu_pkg::CCPU_M_SET_HI: begin
						s_d.latch[i] = 1'b1;
						s_d.flag[i] = 1'b1;
					end
					ccpu_pkg::CCPU_M_SET_LO: begin
						s_d.latch[i] = 1'b0;
						s_d.flag[i] = 1'b1;
					end
					ccpu_pkg::CCPU_M_SOFT: s_d.flag[i] = 1'b1;
					ccpu_pkg::CCPU_M_SPECIAL: begin
						s_d.flag[i] = 1'b1;
						if (useB[i]) begin
							s_d.timerBRst = 1'b1;
						end else begin
							s_d.timerARst = 1'b1;
						end
						if (i == 1) begin
							s_d.adcStart = 1'b1;
						end
					end
					default: ;
				endcase
			end
			if (capEv[i]) begin
				s_d.data[i] = timerVal[i];
				s_d.flag[i] = 1'b1;
			end
			if (pwmMode[i]) begin
				if (periodEvent) begin
					// duty from low byte and bits
					newDuty = {s_q.data[i][7:0],
						s_q.ctrl[i][`CCPU_DUTY_HI:`CCPU_DUTY_LO]};
					s_d.duty[i] = newDuty;
					s_d.latch[i] = (newDuty != 10'h000);
				end else if ({periodTimer, 2'h0} >= s_q.duty[i]) begin
					s_d.latch[i] = 1'b0;
				end
			end
			lvl[i] = s_d.latch[i];
			oe[i] = drivesPin(s_d.ctrl[i][`CCPU_MODE_HI:0]) && !(openDrainSel[i] && lvl[i]);
			out[i] = lvl[i] && !openDrainSel[i];
		end
		s_d.pinAOut = out[0];
		s_d.pinAOe = oe[0];
		s_d.primOut = out[1];
		s_d.primOe = oe[1] && secondPinRouteCfg;
		s_d.altOut = out[1];
		s_d.altOe = oe[1] && !secondPinRouteCfg;
	end

	// frozen while clkEn is low, bus included: a missed setup edge stalls the master for good, a missed access edge drops the write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////

	assign prdata              = s_q.prdata;
	assign pready              = s_q.pready;
	assign pslverr             = s_q.pslverr;
	assign pinAOut             = s_q.pinAOut;
	assign pinAOe              = s_q.pinAOe;
	assign primaryPortPinOut   = s_q.primOut;
	assign primaryPortPinOe    = s_q.primOe;
	assign alternatePortPinOut = s_q.altOut;
	assign alternatePortPinOe  = s_q.altOe;
	assign unitIrqFlag         = s_q.flag;
	assign timerAReset         = s_q.timerARst;
	assign timerBReset         = s_q.timerBRst;
	assign adcStart            = s_q.adcStart;

	////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_off_latch_low: assert property (
		(clkEn && mode[0] == ccpu_pkg::CCPU_M_OFF &&
			!(wrEn && inChan && !ch && paddr[3:0] == `CCPU_SUB_CTRL))
		|=> (!s_q.latch[0] && !pinAOe))
		else $error("off instance still holds or drives its latch");

	a_toggle_match: assert property (
		(clkEn && mode[0] == ccpu_pkg::CCPU_M_TOGGLE && matchEv[0])
		|=> (s_q.latch[0] != $past(s_q.latch[0])) && s_q.flag[0])
		else $error("toggle mode match did not toggle and flag");

	a_force_high: assert property (
		(clkEn && mode[1] == ccpu_pkg::CCPU_M_SET_HI && matchEv[1])
		|=> s_q.latch[1] && s_q.flag[1])
		else $error("match did not force latch high");

	a_force_low: assert property (
		(clkEn && mode[0] == ccpu_pkg::CCPU_M_SET_LO && matchEv[0])
		|=> !s_q.latch[0] && s_q.flag[0])
		else $error("match did not force latch low");

	a_capture_copy: assert property (
		(clkEn && capEv[1]) |=> (s_q.data[1] == $past(timerVal[1])) && s_q.flag[1])
		else $error("capture did not copy the timer");

	a_adc_second_only: assert property (
		s_q.adcStart |-> $past(clkEn && mode[1] == ccpu_pkg::CCPU_M_SPECIAL && matchEv[1]))
		else $error("conversion request without a second instance match");

	a_flag_sticky: assert property (
		(clkEn && s_q.flag[0] && !(wrEn && paddr == `CCPU_OFS_FLAGS)) |=> s_q.flag[0])
		else $error("flag dropped without a software clear");

	a_pwm_duty: assert property (
		(clkEn && pwmMode[0] && periodEvent)
		|=> (s_q.duty[0] == $past({s_q.data[0][7:0], s_q.ctrl[0][5:4]})))
		else $error("duty not latched on period event");

	a_open_drain: assert property (
		(clkEn && openDrainSel[0]) |=> !pinAOut)
		else $error("open-drain pin driven high");

	c_capture: cover property (clkEn && capEv[0]);
	c_special_adc: cover property (s_q.adcStart);
	c_toggle: cover property (clkEn && mode[0] == ccpu_pkg::CCPU_M_TOGGLE && matchEv[0]);
	c_pwm_update: cover property (clkEn && pwmMode[1] && periodEvent);
endmodule

// *** bench/ccpu_far_model.sv ***
/*
 * Far side of the unit: the two 16-bit timers, the period timer and an
 * A/D start counter.
 * Assumes it shares ref_clk and rst_n with the unit.
 */
`timescale 1ns/1ps
module ccpu_far_model (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// bench control
	input  wire logic        run,
	input  wire logic        clr,
	// unit side effects
	input  wire logic        timerAReset,
	input  wire logic        timerBReset,
	input  wire logic        adcStart,
	// time bases
	output logic [15:0]      timerACount,
	output logic [15:0]      timerBCount,
	output logic [7:0]       periodTimer,
	output logic             periodEvent,
	output logic [7:0]       adcCount
);
	////////////////////////////////////////////////////////////////////////
	// timers count in step with ref_clk, so compare never sees a torn value
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			timerACount <= 16'h0000;
			timerBCount <= 16'h0000;
			periodTimer <= 8'h00;
			periodEvent <= 1'b0;
			adcCount    <= 8'h00;
		end else begin
			timerACount <= (clr || timerAReset) ? 16'h0000 : timerACount + {15'h0000, run};
			timerBCount <= (clr || timerBReset) ? 16'h0000 : timerBCount + {15'h0000, run};
			periodTimer <= (periodTimer == 8'h3F) ? 8'h00 : periodTimer + 8'h01;
			periodEvent <= (periodTimer == 8'h3F);
			adcCount    <= adcCount + {7'h00, adcStart};
		end
	end
endmodule

// *** bench/testbench.sv ***
/*
 * Self-checking bench of the two-instance capture/compare/PWM unit.
 * Assumes the package, the unit and ccpu_far_model are compiled first.
 */
`timescale 1ns/1ps
`include "ccpu_cfg.svh"
module testbench;
	logic        ref_clk      = 1'b0;
	logic        rst_n        = 1'b0;
	logic        psel         = 1'b0;
	logic        penable      = 1'b0;
	logic        pwrite       = 1'b0;
	logic [7:0]  paddr        = 8'h00;
	logic [31:0] pwdata       = 32'h0;
	logic [1:0]  timerSelect  = 2'h0;
	logic [1:0]  openDrainSel = 2'h0;
	logic        route        = 1'b1;
	logic        tbPinA       = 1'b0;
	logic        tbPinP       = 1'b0;
	logic        tbPinE       = 1'b0;
	logic        run          = 1'b1;
	logic        clr          = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pinAOut;
	logic        pinAOe;
	logic        primOut;
	logic        primOe;
	logic        altOut;
	logic        altOe;
	logic [1:0]  irq;
	logic        tAR;
	logic        tBR;
	logic        adcStart;
	logic [15:0] tA;
	logic [15:0] tB;
	logic [7:0]  pTmr;
	logic        pEvt;
	logic [7:0]  adcCount;
	logic [31:0] rd;
	logic        er;
	int          badCount     = 0;
	int          testsRun     = 0;
	// released pins float to the bench level (pull-up stands in when high)
	wire         pinA         = pinAOe ? pinAOut : tbPinA;
	wire         pinP         = primOe ? primOut : tbPinP;
	wire         pinE         = altOe ? altOut : tbPinE;

	always #4 ref_clk = ~ref_clk;

	ccpu_top dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timerACount(tA), .timerBCount(tB), .timerSelect(timerSelect),
		.periodTimer(pTmr), .periodEvent(pEvt), .openDrainSel(openDrainSel),
		.secondPinRouteCfg(route), .pinAIn(pinA), .pinAOut(pinAOut), .pinAOe(pinAOe),
		.primaryPortPinIn(pinP), .primaryPortPinOut(primOut), .primaryPortPinOe(primOe),
		.alternatePortPinIn(pinE), .alternatePortPinOut(altOut), .alternatePortPinOe(altOe),
		.unitIrqFlag(irq), .timerAReset(tAR), .timerBReset(tBR), .adcStart(adcStart)
	);

	ccpu_far_model far (
		.ref_clk(ref_clk), .rst_n(rst_n), .run(run), .clr(clr),
		.timerAReset(tAR), .timerBReset(tBR), .adcStart(adcStart),
		.timerACount(tA), .timerBCount(tB), .periodTimer(pTmr),
		.periodEvent(pEvt), .adcCount(adcCount)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic endSim();
		$display("checks %0d mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic hang();
		badCount++;
		$display("ERROR wait expected answer seen none");
		endSim();
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			badCount++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) hang();
		#1;
	endtask

	function automatic logic sig(input int k);
		case (k)
			0: return pinAOut;
			1: return pinAOe;
			2: return tAR;
			default: return tBR;
		endcase
	endfunction

	task automatic waitFor(input int k);
		int n;
		for (n = 0; n < 400; n++) begin
			@(posedge ref_clk);
			if (sig(k) === 1'b1) break;
		end
		if (n == 400) hang();
	endtask

	task automatic restart();
		@(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
	endtask

	task automatic setPin(input int k, input logic v);
		@(posedge ref_clk);
		case (k)
			0: tbPinA <= v;
			1: tbPinP <= v;
			default: tbPinE <= v;
		endcase
		repeat (8) @(posedge ref_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic regTest();
		apb(1'b0, 8'h10, 32'h0);
		chk("ctrl1 reset", 32'h0, rd);
		apb(1'b1, 8'h00, 32'hFF);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl0 rw", 32'h3F, rd);
		apb(1'b1, 8'h04, 32'hA5);
		apb(1'b0, 8'h04, 32'h0);
		chk("data low", 32'hA5, rd);
		apb(1'b1, 8'h18, 32'h5A);
		apb(1'b0, 8'h18, 32'h0);
		chk("data high", 32'h5A, rd);
		apb(1'b1, 8'h30, 32'hFF);
		chk("unmapped err", 32'h1, er);
		apb(1'b1, 8'h00, 32'h0);
	endtask

	task automatic cmpTest();
		apb(1'b1, 8'h04, 32'h40);
		apb(1'b1, 8'h08, 32'h00);
		restart();
		apb(1'b1, 8'h00, 32'h08);
		chk("entry low", 32'h0, pinAOut);
		chk("entry driven", 32'h1, pinAOe);
		waitFor(0);
		chk("match time", 32'h41, tA);
		chk("match flag", 32'h1, irq[0]);
		apb(1'b1, 8'h20, 32'h2);
		chk("flag cleared", 32'h0, irq[0]);
		apb(1'b1, 8'h00, 32'h0);
		chk("latch off", 32'h0, pinAOut);
		chk("off released", 32'h0, pinAOe);
		@(posedge ref_clk);
		openDrainSel <= 2'h1;
		// pull-up holds the released open-drain pin high
		tbPinA <= 1'b1;
		apb(1'b1, 8'h04, 32'h30);
		restart();
		apb(1'b1, 8'h00, 32'h09);
		repeat (2) @(posedge ref_clk);
		chk("od released", 32'h0, pinAOe);
		chk("entry high", 32'h1, pinA);
		waitFor(1);
		chk("od low", 32'h0, pinAOut);
		chk("flag 1001", 32'h1, irq[0]);
		apb(1'b1, 8'h00, 32'h0);
		@(posedge ref_clk);
		openDrainSel <= 2'h0;
		tbPinA <= 1'b0;
	endtask

	task automatic evtTest();
		logic [7:0] n0;
		@(posedge ref_clk);
		timerSelect <= 2'h1;
		apb(1'b1, 8'h14, 32'h20);
		apb(1'b1, 8'h18, 32'h00);
		restart();
		apb(1'b1, 8'h10, 32'h0B);
		waitFor(3);
		chk("second adc", 32'h1, adcStart);
		chk("timer a kept", 32'h0, tAR);
		apb(1'b1, 8'h10, 32'h0);
		n0 = adcCount;
		@(posedge ref_clk);
		timerSelect <= 2'h2;
		apb(1'b1, 8'h00, 32'h0B);
		waitFor(3);
		chk("first on b", 32'h0, tAR);
		repeat (100) @(posedge ref_clk);
		chk("first no adc", n0, adcCount);
		apb(1'b1, 8'h00, 32'h0);
		@(posedge ref_clk);
		timerSelect <= 2'h0;
	endtask

	task automatic capTest();
		logic [7:0] lo;
		@(posedge ref_clk);
		run <= 1'b0;
		apb(1'b1, 8'h00, 32'h06);
		// mode change may leave a false flag, so software clears it
		apb(1'b1, 8'h20, 32'h6);
		repeat (2) begin
			setPin(0, 1'b1);
			setPin(0, 1'b0);
		end
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h00, 32'h06);
		apb(1'b1, 8'h20, 32'h2);
		repeat (3) begin
			setPin(0, 1'b1);
			setPin(0, 1'b0);
		end
		chk("prescaler clear", 32'h0, irq[0]);
		setPin(0, 1'b1);
		chk("fourth rise", 32'h1, irq[0]);
		apb(1'b0, 8'h04, 32'h0);
		lo = rd[7:0];
		apb(1'b0, 8'h08, 32'h0);
		chk("capture value", {16'h0, tA}, {16'h0, rd[7:0], lo});
		apb(1'b1, 8'h00, 32'h04);
		apb(1'b1, 8'h20, 32'h2);
		setPin(0, 1'b0);
		apb(1'b1, 8'h20, 32'h2);
		setPin(0, 1'b1);
		chk("rise ignored", 32'h0, irq[0]);
		run <= 1'b1;
		repeat (7) @(posedge ref_clk);
		run <= 1'b0;
		setPin(0, 1'b0);
		chk("fall flag", 32'h1, irq[0]);
		apb(1'b0, 8'h04, 32'h0);
		chk("overwrite", {24'h0, tA[7:0]}, rd);
		apb(1'b1, 8'h00, 32'h0);
	endtask

	task automatic routeTest();
		@(posedge ref_clk);
		route <= 1'b0;
		apb(1'b1, 8'h10, 32'h05);
		apb(1'b1, 8'h20, 32'h4);
		setPin(1, 1'b1);
		chk("primary unused", 32'h0, irq[1]);
		setPin(2, 1'b1);
		chk("alternate used", 32'h1, irq[1]);
		apb(1'b1, 8'h10, 32'h09);
		chk("alternate driven", 32'h3, {altOe, altOut});
		chk("primary released", 32'h0, primOe);
		apb(1'b1, 8'h10, 32'h0);
		chk("alternate off", 32'h0, altOe);
	endtask

	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		regTest();
		cmpTest();
		evtTest();
		capTest();
		routeTest();
		endSim();
	end
endmodule
